// file: verilog/dtq_regs.vh
`ifndef DTQ_REGS_VH
`define DTQ_REGS_VH
// ------
// register byte offsets
// ------
`define DTQ_CTRL_OFF 8'h00
`define DTQ_COND_OFF 8'h04
`define DTQ_LEVEL1_OFF 8'h08
`define DTQ_LEVEL2_OFF 8'h0c
`define DTQ_EDGES_OFF 8'h10
`define DTQ_IRQEN_OFF 8'h14
`define DTQ_RTINT_OFF 8'h18
`define DTQ_STATUS_OFF 8'h1c
`define DTQ_PKMAX_OFF 8'h20
`define DTQ_PKMIN_OFF 8'h24
`define DTQ_DELIM_OFF 8'h28
// ------
// control bits (write one to act)
// ------
`define DTQ_CTRL_ARM 0
`define DTQ_CTRL_SWTRG 1
`define DTQ_CTRL_BUSTRG 2
// ------
// condition register fields
// ------
`define DTQ_COND_A_LSB 0
`define DTQ_COND_B_LSB 4
`define DTQ_COND_AND 8
`define DTQ_COND_PAIR 9
`define DTQ_COND_INSEL_LSB 12
`define DTQ_COND_OUTEN 15
`define DTQ_COND_OUTSEL_LSB 16
`define DTQ_COND_RECORD_COLLECT_MODE 20
`define DTQ_COND_RST 21'h000000
// ------
// condition source codes
// ------
`define DTQ_SOFTWARE_TRIGGER_CODE 4'h0
`define DTQ_BUS_COMMAND_TRIGGER_CODE 4'h1
`define DTQ_EXT_RISE_CODE 4'h2
`define DTQ_EXT_FALL_CODE 4'h3
`define DTQ_BACKPLANE_CODE 4'h4
`define DTQ_ABOVE_LEVEL_CODE 4'h5
`define DTQ_BELOW_LEVEL_CODE 4'h6
`define DTQ_RISING_SLOPE_CODE 4'h7
`define DTQ_FALLING_SLOPE_CODE 4'h8
// ------
// edge polarity bits, one = positive edge
// ------
`define DTQ_EDGE_BPIN 0
`define DTQ_EDGE_BPOUT 1
`define DTQ_EDGE_ARMIN 2
`define DTQ_EDGE_ARMOUT 3
`define DTQ_EDGES_RST 4'h0
// ------
// reset values and scale
// ------
`define DTQ_LEVEL1_RST 16'h7fff
`define DTQ_LEVEL2_RST 16'h8000
`define DTQ_IRQEN_RST 5'h00
`define DTQ_RTINT_RST 24'h000001
`define DTQ_DELIM_RST 8'h3b
`define DTQ_SEMICOLON 8'h3b
`define DTQ_NEG_FS 16'h8000
`define DTQ_POS_FS 16'h7fff
`define DTQ_HALF_STEP 17'h00080
`endif

// file: verilog/dtq_trigger_qualifier.v
// What this block does
// - threshold compare uses only the top eight bits of each sample.
// - requested level is rounded to the nearest eight-bit step before use.
// - after trigger, peak one takes every larger sample: running maximum.
// - after trigger, peak two takes every smaller sample: running minimum.
// - record collection mode freezes both peak trackers.
// - no threshold condition: peak one preloads minus, peak two plus full scale.
// - an active external gate stops both peak trackers.
// - AND mode latches the first met condition, fires on the other, any order.
// - in AND mode a level or slope detector waits for the other condition, unless both sides are level based: then side a may go first.
// - selected backplane output line zero to seven strobes at trigger, else none.
// - slope detector takes either direction with any signed level.
// - OR mode fires on either condition; window setup fires on leaving band.
// - four control-line edge polarity bits are stored; only the backplane input edge uses its bit.
// - five interrupt sources each carry their own enable bit.
// - realtime value refreshes every programmed sample clocks, default one.
// - trigger setup stays pending until arm; irq enables, realtime interval and delimiter act at once; reads return the pending values.
// - reset gives software OR software, post-trigger, edges unprogrammed.
// - report text swaps each semicolon for the selected delimiter.
// - above-level fires when input exceeds level, below-level when under it.
// - slope fires one sample clock after crossing the level the right way.
// - external edge fires only on a real transition of the programmed sense.
// - with no operator the single condition is ORed with itself.
`timescale 1ns/1ps
`include "dtq_regs.vh"

module dtq_trigger_qualifier (
  // clock and reset
  input wire clk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // sample stream, same clock
  input wire [15:0] sample,
  // pins from outside
  input wire ext_trig,
  input wire ext_gate,
  input wire [7:0] bp_trig_in,
  // backplane output trigger, open collector
  output wire [7:0] bp_trig_o,
  output reg [7:0] bp_trig_oe,
  // status and side outputs
  output reg trig_pulse,
  output reg armed,
  output reg [4:0] irq_enable,
  output reg [15:0] rt_data,
  output reg rt_update,
  // setup report text
  input wire [7:0] report_char,
  input wire report_valid,
  output reg [7:0] report_char_out,
  output reg report_valid_out
);

  // ------
  // pending setup registers
  // ------
  reg [20:0] cond_ff;
  reg [15:0] level1_ff;
  reg [15:0] level2_ff;
  reg [3:0] edges_ff;
  reg [23:0] rtint_ff;
  reg [7:0] delim_ff;
  // ------
  // active setup, loaded at arm
  // ------
  reg [20:0] act_cond_ff;
  reg [7:0] act_thr1_ff;
  reg [7:0] act_thr2_ff;
  reg act_bpin_pos_ff;
  // ------
  // trigger state
  // ------
  reg triggered_ff;
  reg latch_a_ff;
  reg latch_b_ff;
  reg [15:0] pkmax_ff;
  reg [15:0] pkmin_ff;
  reg [23:0] rtcnt_ff;
  // ------
  // synchronisers and registered sources
  // ------
  reg [9:0] sync1_ff;
  reg [9:0] sync2_ff;
  reg [9:0] sync3_ff;
  reg [7:0] prev8_ff;
  reg sw_ev_ff;
  reg bus_ev_ff;
  reg slope_rise_ff;
  reg slope_fall_ff;

  wire wr_en = psel & penable & pwrite;
  wire arm_cmd = wr_en & (paddr == `DTQ_CTRL_OFF) & pwdata[`DTQ_CTRL_ARM];
  wire sw_cmd = wr_en & (paddr == `DTQ_CTRL_OFF) & pwdata[`DTQ_CTRL_SWTRG];
  wire bus_cmd = wr_en & (paddr == `DTQ_CTRL_OFF) & pwdata[`DTQ_CTRL_BUSTRG];

  // ------
  // threshold rounding
  // ------
  // round to nearest step, saturating so a level near plus full scale cannot wrap
  function [7:0] dtq_round;
    input [15:0] req;
    reg [16:0] sum;
    begin
      sum = {req[15], req} + `DTQ_HALF_STEP;
      if (!req[15] && sum[15])
        dtq_round = 8'h7f;
      else
        dtq_round = sum[15:8];
    end
  endfunction

  function is_level;
    input [3:0] code;
    begin
      is_level = (code == `DTQ_ABOVE_LEVEL_CODE) || (code == `DTQ_BELOW_LEVEL_CODE) ||
                 (code == `DTQ_RISING_SLOPE_CODE) || (code == `DTQ_FALLING_SLOPE_CODE);
    end
  endfunction

  function is_thr;
    input [3:0] code;
    begin
      is_thr = (code == `DTQ_ABOVE_LEVEL_CODE) || (code == `DTQ_BELOW_LEVEL_CODE);
    end
  endfunction

  // ------
  // source detection
  // ------
  wire [7:0] s8 = sample[15:8];
  wire ext_s = sync2_ff[8];
  wire ext_d = sync3_ff[8];
  wire gate_s = sync2_ff[9];
  wire [2:0] in_sel = act_cond_ff[`DTQ_COND_INSEL_LSB +: 3];
  wire bp_s = sync2_ff[in_sel];
  wire bp_d = sync3_ff[in_sel];
  wire bp_edge = act_bpin_pos_ff ? (bp_s & ~bp_d) : (~bp_s & bp_d);
  wire ext_rise = ext_s & ~ext_d;
  wire ext_fall = ~ext_s & ext_d;

  function src_hit;
    input [3:0] code;
    input [7:0] thr;
    input [7:0] smp;
    input sw_e;
    input bus_e;
    input er;
    input ef;
    input bpe;
    input sr;
    input sf;
    begin
      case (code)
        `DTQ_SOFTWARE_TRIGGER_CODE: src_hit = sw_e;
        `DTQ_BUS_COMMAND_TRIGGER_CODE: src_hit = bus_e;
        `DTQ_EXT_RISE_CODE: src_hit = er;
        `DTQ_EXT_FALL_CODE: src_hit = ef;
        `DTQ_BACKPLANE_CODE: src_hit = bpe;
        `DTQ_ABOVE_LEVEL_CODE: src_hit = $signed(smp) > $signed(thr);
        `DTQ_BELOW_LEVEL_CODE: src_hit = $signed(smp) < $signed(thr);
        `DTQ_RISING_SLOPE_CODE: src_hit = sr;
        `DTQ_FALLING_SLOPE_CODE: src_hit = sf;
        default: src_hit = 1'b0;
      endcase
    end
  endfunction

  wire [3:0] code_a = act_cond_ff[`DTQ_COND_A_LSB +: 4];
  // without an operator the second condition mirrors the first
  wire pair = act_cond_ff[`DTQ_COND_PAIR];
  wire [3:0] code_b = pair ? act_cond_ff[`DTQ_COND_B_LSB +: 4] : code_a;
  wire [7:0] thr_b = pair ? act_thr2_ff : act_thr1_ff;
  wire and_mode = act_cond_ff[`DTQ_COND_AND] & pair;

  // slope crossings per side, each threshold signed so all quadrants work
  wire rise_x1 = ($signed(prev8_ff) <= $signed(act_thr1_ff)) &
                 ($signed(s8) > $signed(act_thr1_ff));
  wire fall_x1 = ($signed(prev8_ff) >= $signed(act_thr1_ff)) &
                 ($signed(s8) < $signed(act_thr1_ff));
  wire rise_x2 = ($signed(prev8_ff) <= $signed(thr_b)) & ($signed(s8) > $signed(thr_b));
  wire fall_x2 = ($signed(prev8_ff) >= $signed(thr_b)) & ($signed(s8) < $signed(thr_b));
  reg slope_rise2_ff;
  reg slope_fall2_ff;

  wire raw_a = src_hit(code_a, act_thr1_ff, s8, sw_ev_ff, bus_ev_ff, ext_rise, ext_fall,
                       bp_edge, slope_rise_ff, slope_fall_ff);
  wire raw_b = src_hit(code_b, thr_b, s8, sw_ev_ff, bus_ev_ff, ext_rise, ext_fall,
                       bp_edge, slope_rise2_ff, slope_fall2_ff);

  // level detectors in AND mode wait for the other side; if both are
  // level based, side a is allowed first so the pair can still complete
  wire lvl_a = is_level(code_a);
  wire lvl_b = is_level(code_b);
  wire en_a = ~and_mode | ~lvl_a | lvl_b | latch_b_ff;
  wire en_b = ~and_mode | ~lvl_b | latch_a_ff;
  wire hit_a = raw_a & en_a;
  wire hit_b = raw_b & en_b;
  wire fire_or = hit_a | hit_b;
  wire fire_and = (hit_a | latch_a_ff) & (hit_b | latch_b_ff);
  wire fire = armed & ~arm_cmd & (and_mode ? fire_and : fire_or);
  wire any_thr = is_thr(cond_ff[`DTQ_COND_A_LSB +: 4]) |
                 (cond_ff[`DTQ_COND_PAIR] & is_thr(cond_ff[`DTQ_COND_B_LSB +: 4]));

  // ------
  // apb access
  // ------
  assign pready = 1'b1;
  reg mapped;
  always @*
  begin
    mapped = 1'b1;
    case (paddr)
      `DTQ_CTRL_OFF: prdata = 32'h00000000;
      `DTQ_COND_OFF: prdata = {11'h000, cond_ff};
      `DTQ_LEVEL1_OFF: prdata = {16'h0000, level1_ff};
      `DTQ_LEVEL2_OFF: prdata = {16'h0000, level2_ff};
      `DTQ_EDGES_OFF: prdata = {28'h0000000, edges_ff};
      `DTQ_IRQEN_OFF: prdata = {27'h0000000, irq_enable};
      `DTQ_RTINT_OFF: prdata = {8'h00, rtint_ff};
      `DTQ_STATUS_OFF: prdata = {28'h0000000, latch_b_ff, latch_a_ff, triggered_ff, armed};
      `DTQ_PKMAX_OFF: prdata = {16'h0000, pkmax_ff};
      `DTQ_PKMIN_OFF: prdata = {16'h0000, pkmin_ff};
      `DTQ_DELIM_OFF: prdata = {24'h000000, delim_ff};
      default:
      begin
        prdata = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // ------
  // pending setup writes
  // ------
  always @(posedge clk)
  begin
    if (srst)
    begin
      cond_ff <= `DTQ_COND_RST;
      level1_ff <= `DTQ_LEVEL1_RST;
      level2_ff <= `DTQ_LEVEL2_RST;
      edges_ff <= `DTQ_EDGES_RST;
      irq_enable <= `DTQ_IRQEN_RST;
      rtint_ff <= `DTQ_RTINT_RST;
      delim_ff <= `DTQ_DELIM_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `DTQ_COND_OFF: cond_ff <= pwdata[20:0];
        `DTQ_LEVEL1_OFF: level1_ff <= pwdata[15:0];
        `DTQ_LEVEL2_OFF: level2_ff <= pwdata[15:0];
        `DTQ_EDGES_OFF: edges_ff <= pwdata[3:0];
        `DTQ_IRQEN_OFF: irq_enable <= pwdata[4:0];
        `DTQ_RTINT_OFF: rtint_ff <= pwdata[23:0];
        `DTQ_DELIM_OFF: delim_ff <= pwdata[7:0];
        default: delim_ff <= delim_ff;
      endcase
    end
  end

  // ------
  // source registers and synchronisers
  // ------
  always @(posedge clk)
  begin
    if (srst)
    begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
      sync3_ff <= 10'h000;
      prev8_ff <= 8'h00;
      sw_ev_ff <= 1'b0;
      bus_ev_ff <= 1'b0;
      slope_rise_ff <= 1'b0;
      slope_fall_ff <= 1'b0;
      slope_rise2_ff <= 1'b0;
      slope_fall2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {ext_gate, ext_trig, bp_trig_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      prev8_ff <= s8;
      sw_ev_ff <= sw_cmd;
      bus_ev_ff <= bus_cmd;
      slope_rise_ff <= rise_x1;
      slope_fall_ff <= fall_x1;
      slope_rise2_ff <= rise_x2;
      slope_fall2_ff <= fall_x2;
    end
  end

  // ------
  // arm, latch and trigger
  // ------
  wire outen = act_cond_ff[`DTQ_COND_OUTEN];
  wire [2:0] out_sel = act_cond_ff[`DTQ_COND_OUTSEL_LSB +: 3];
  assign bp_trig_o = 8'h00;

  always @(posedge clk)
  begin
    if (srst)
    begin
      act_cond_ff <= `DTQ_COND_RST;
      act_thr1_ff <= 8'h7f;
      act_thr2_ff <= 8'h80;
      act_bpin_pos_ff <= 1'b0;
      armed <= 1'b0;
      triggered_ff <= 1'b0;
      latch_a_ff <= 1'b0;
      latch_b_ff <= 1'b0;
      trig_pulse <= 1'b0;
      bp_trig_oe <= 8'h00;
    end
    else
    begin
      trig_pulse <= fire;
      bp_trig_oe <= (fire & outen) ? (8'h01 << out_sel) : 8'h00;
      if (arm_cmd)
      begin
        act_cond_ff <= cond_ff;
        act_thr1_ff <= dtq_round(level1_ff);
        act_thr2_ff <= dtq_round(level2_ff);
        act_bpin_pos_ff <= edges_ff[`DTQ_EDGE_BPIN];
        armed <= 1'b1;
        triggered_ff <= 1'b0;
        latch_a_ff <= 1'b0;
        latch_b_ff <= 1'b0;
      end
      else if (fire)
      begin
        armed <= 1'b0;
        triggered_ff <= 1'b1;
        latch_a_ff <= 1'b0;
        latch_b_ff <= 1'b0;
      end
      else if (armed & and_mode)
      begin
        if (hit_a)
          latch_a_ff <= 1'b1;
        if (hit_b)
          latch_b_ff <= 1'b1;
      end
    end
  end

  // ------
  // peak trackers
  // ------
  wire pk_run = triggered_ff & ~act_cond_ff[`DTQ_COND_RECORD_COLLECT_MODE] & ~gate_s;
  always @(posedge clk)
  begin
    if (srst)
    begin
      pkmax_ff <= `DTQ_NEG_FS;
      pkmin_ff <= `DTQ_POS_FS;
    end
    else if (arm_cmd)
    begin
      pkmax_ff <= any_thr ? {dtq_round(level1_ff), 8'h00} : `DTQ_NEG_FS;
      pkmin_ff <= any_thr ? {dtq_round(level2_ff), 8'h00} : `DTQ_POS_FS;
    end
    else if (pk_run)
    begin
      if ($signed(sample) > $signed(pkmax_ff))
        pkmax_ff <= sample;
      if ($signed(sample) < $signed(pkmin_ff))
        pkmin_ff <= sample;
    end
  end

  // ------
  // realtime update
  // ------
  // an interval of zero behaves as one so the value never goes stale
  wire rt_hit = (rtcnt_ff + 24'h000001 >= rtint_ff);
  always @(posedge clk)
  begin
    if (srst)
    begin
      rtcnt_ff <= 24'h000000;
      rt_data <= 16'h0000;
      rt_update <= 1'b0;
    end
    else
    begin
      rt_update <= rt_hit;
      if (rt_hit)
      begin
        rtcnt_ff <= 24'h000000;
        rt_data <= sample;
      end
      else
        rtcnt_ff <= rtcnt_ff + 24'h000001;
    end
  end

  // ------
  // report delimiter swap
  // ------
  always @(posedge clk)
  begin
    if (srst)
    begin
      report_char_out <= 8'h00;
      report_valid_out <= 1'b0;
    end
    else
    begin
      report_valid_out <= report_valid;
      report_char_out <= (report_char == `DTQ_SEMICOLON) ? delim_ff : report_char;
    end
  end

endmodule

// file: verification/dtq_trigger_qualifier_chk.sv
`timescale 1ns/1ps
`include "dtq_regs.vh"
module dtq_trigger_qualifier_chk (
  // clock and reset
  input wire clk,
  input wire srst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // samples and pins
  input wire [15:0] sample,
  input wire [7:0] bp_trig_o,
  input wire [7:0] bp_trig_oe,
  // status and side outputs
  input wire trig_pulse,
  input wire armed,
  input wire [15:0] rt_data,
  input wire rt_update,
  // report text
  input wire [7:0] report_char,
  input wire report_valid,
  input wire [7:0] report_char_out,
  input wire report_valid_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  reg [7:0] delim_ff;
  // delimiter mirror, no bus read needed
  always @(posedge clk)
  begin
    if (srst)
      delim_ff <= `DTQ_DELIM_RST;
    else if (psel && penable && pwrite && paddr == `DTQ_DELIM_OFF)
      delim_ff <= pwdata[7:0];
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_arm_wr;
    psel && penable && pwrite && paddr == `DTQ_CTRL_OFF && pwdata[`DTQ_CTRL_ARM];
  endsequence
  sequence s_one_shot;
    trig_pulse ##1 (!trig_pulse && bp_trig_oe == 8'h00);
  endsequence
  AST_ARM_NEXT: assert property (s_arm_wr |=> armed)
    else $error("armed not set after arm write");
  AST_TRIG_ONE: assert property (trig_pulse |-> s_one_shot)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_DISARM: assert property (trig_pulse |-> !armed && $past(armed))
    else $error("trigger without prior arm");
  AST_OE_SEL: assert property (bp_trig_oe != 8'h00 |-> trig_pulse && $onehot(bp_trig_oe))
    else $error("output line strobed outside trigger");
  AST_OC_LOW: assert property (bp_trig_o == 8'h00)
    else $error("open collector output not low");
  AST_UNMAPPED: assert property (
    s_access ##0 (paddr > `DTQ_DELIM_OFF) |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (
    s_access ##0 (paddr <= `DTQ_DELIM_OFF && paddr[1:0] == 2'b00) |-> pready && !pslverr)
    else $error("mapped access refused");
  AST_RT_DATA: assert property (rt_update |-> rt_data == $past(sample))
    else $error("realtime value not the sample of its cycle");
  AST_DELIM_SWAP: assert property (
    report_valid && report_char == `DTQ_SEMICOLON |=>
    report_valid_out && report_char_out == $past(delim_ff))
    else $error("separator not replaced by delimiter");
  AST_TEXT_PASS: assert property (
    report_valid && report_char != `DTQ_SEMICOLON |=>
    report_valid_out && report_char_out == $past(report_char))
    else $error("text character altered");
endmodule

bind dtq_trigger_qualifier dtq_trigger_qualifier_chk u_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample(sample), .bp_trig_o(bp_trig_o), .bp_trig_oe(bp_trig_oe), .trig_pulse(trig_pulse),
  .armed(armed), .rt_data(rt_data), .rt_update(rt_update),
  .report_char(report_char), .report_valid(report_valid),
  .report_char_out(report_char_out), .report_valid_out(report_valid_out));

// file: verification/dtq_bp_model.sv
`timescale 1ns/1ps
module dtq_bp_model (
  // clock
  input wire clk,
  // pulse request from the bench
  input wire pulse_req,
  input wire [2:0] pulse_line,
  // device output enables
  input wire [7:0] dut_oe,
  // wired lines, pulled up
  output wire [7:0] bp_lines
);
  reg [7:0] hold_ff;
  reg [2:0] cnt_ff;
  initial
  begin
    hold_ff = 8'h00;
    cnt_ff = 3'h0;
  end
  // held low several cycles so the device synchroniser cannot miss it
  always @(posedge clk)
  begin
    if (pulse_req)
    begin
      hold_ff <= 8'h01 << pulse_line;
      cnt_ff <= 3'h4;
    end
    else if (cnt_ff != 3'h0)
      cnt_ff <= cnt_ff - 3'h1;
    else
      hold_ff <= 8'h00;
  end
  // open collector: low while any party pulls, pull-up otherwise
  assign bp_lines = ~(hold_ff | dut_oe);
endmodule

// file: verification/dtq_trigger_qualifier_tb.sv
`timescale 1ns/1ps
`include "dtq_regs.vh"
module dtq_trigger_qualifier_tb;
  reg clk, srst, psel, penable, pwrite, ext_trig, ext_gate, rpt_v, bp_req, err;
  reg [7:0] paddr, rpt_c, oe_seen;
  reg [31:0] pwdata, rd, rv;
  reg [15:0] sample, v, mx, mn;
  reg [2:0] bp_line;
  wire [31:0] prdata;
  wire pready, pslverr, trig_pulse, armed, rt_update, rpt_vo;
  wire [7:0] bp_lines, bp_oe, rpt_co;
  wire [4:0] irq_en;
  wire [15:0] rt_data;
  integer fails, num_checks, i, k;
  dtq_trigger_qualifier u_dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .ext_trig(ext_trig), .ext_gate(ext_gate), .bp_trig_in(bp_lines), .bp_trig_o(),
    .bp_trig_oe(bp_oe), .trig_pulse(trig_pulse), .armed(armed), .irq_enable(irq_en),
    .rt_data(rt_data), .rt_update(rt_update), .report_char(rpt_c), .report_valid(rpt_v),
    .report_char_out(rpt_co), .report_valid_out(rpt_vo));
  dtq_bp_model u_bp (.clk(clk), .pulse_req(bp_req), .pulse_line(bp_line), .dut_oe(bp_oe),
    .bp_lines(bp_lines));
  // ------
  // expectations and checks
  // ------
  function [31:0] rst_val(input [7:0] a);
    case (a)
      `DTQ_LEVEL1_OFF: rst_val = {16'h0000, `DTQ_LEVEL1_RST};
      `DTQ_LEVEL2_OFF: rst_val = {16'h0000, `DTQ_LEVEL2_RST};
      `DTQ_RTINT_OFF: rst_val = {8'h00, `DTQ_RTINT_RST};
      `DTQ_PKMAX_OFF: rst_val = {16'h0000, `DTQ_NEG_FS};
      `DTQ_PKMIN_OFF: rst_val = {16'h0000, `DTQ_POS_FS};
      `DTQ_DELIM_OFF: rst_val = {24'h000000, `DTQ_DELIM_RST};
      default: rst_val = 32'h00000000;
    endcase
  endfunction
  // nearest eight-bit step, clipped at positive full scale
  function [7:0] thr_of(input [15:0] l);
    reg [16:0] s;
  begin
    s = {l[15], l} + 17'h00080;
    thr_of = (!s[16] && s[15]) ? 8'h7f : s[15:8];
  end
  endfunction
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk_word(input [8*16-1:0] name, input [31:0] exp, input [31:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      $display("mismatch %0s expected %h seen %h", name, exp, got);
      fails = fails + 1;
    end
  end
  endtask
  task chk_bit(input [8*16-1:0] name, input exp, input got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      $display("mismatch %0s expected %b seen %b", name, exp, got);
      fails = fails + 1;
    end
  end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk_bit("pready", 1'b1, pready);
    if (n >= 50)
      end_sim;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task arm(input [31:0] cond, input [15:0] l1, input [15:0] l2);
  begin
    apb(1'b1, `DTQ_COND_OFF, cond);
    apb(1'b1, `DTQ_LEVEL1_OFF, {16'h0000, l1});
    apb(1'b1, `DTQ_LEVEL2_OFF, {16'h0000, l2});
    apb(1'b1, `DTQ_CTRL_OFF, 32'h1 << `DTQ_CTRL_ARM);
  end
  endtask
  task hold(input [15:0] s, input integer n);
  begin
    @(posedge clk);
    sample <= s;
    repeat (n) @(posedge clk);
  end
  endtask
  task wait_fire(input exp, input integer n);
    integer j;
    reg seen;
  begin
    seen = 1'b0;
    oe_seen = 8'h00;
    for (j = 0; j < n && !seen; j = j + 1)
    begin
      @(posedge clk);
      if (trig_pulse === 1'b1)
      begin
        seen = 1'b1;
        oe_seen = bp_oe;
      end
    end
    chk_bit("trig_pulse", exp, seen);
    if (exp && !seen)
      end_sim;
  end
  endtask
  task rt_gap(output integer n);
  begin
    n = 0;
    @(posedge clk);
    while (rt_update !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n = n + 1;
    end
    n = n + 1;
  end
  endtask
  // ------
  // clock and main sequence
  // ------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    fails = 0;
    num_checks = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sample = 16'h0000;
    ext_trig = 1'b0;
    ext_gate = 1'b0;
    rpt_c = 8'h00;
    rpt_v = 1'b0;
    bp_req = 1'b0;
    bp_line = 3'h0;
    rv = $urandom(32'h32d4fd3f);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 12; i = i + 1)
    begin
      apb(1'b0, {i[5:0], 2'b00}, 32'h00000000);
      chk_word("reset value", rst_val({i[5:0], 2'b00}), rd);
      chk_bit("pslverr", i > 10, err);
    end
    apb(1'b1, `DTQ_IRQEN_OFF, 32'h00000015);
    @(posedge clk);
    chk_word("irq_enable", 32'h00000015, {27'h0000000, irq_en});
    $display("test reset done");
    // pending setup has no effect until armed
    apb(1'b1, `DTQ_COND_OFF, {28'h0000000, `DTQ_ABOVE_LEVEL_CODE});
    apb(1'b1, `DTQ_LEVEL1_OFF, 32'h00001000);
    hold(16'h2000, 0);
    wait_fire(1'b0, 8);
    apb(1'b0, `DTQ_COND_OFF, 32'h00000000);
    chk_word("pending cond", {28'h0000000, `DTQ_ABOVE_LEVEL_CODE}, rd);
    hold(16'h0000, 0);
    // software trigger, output line, record mode freezes peaks
    for (k = 0; k < 2; k = k + 1)
    begin
      rv = $urandom;
      arm((k << `DTQ_COND_OUTEN) | (rv[2:0] << `DTQ_COND_OUTSEL_LSB) |
        (32'h1 << `DTQ_COND_RECORD_COLLECT_MODE), 16'h0000, 16'h0000);
      apb(1'b1, `DTQ_CTRL_OFF, 32'h1 << `DTQ_CTRL_SWTRG);
      wait_fire(1'b1, 8);
      chk_word("output line", k ? (32'h1 << rv[2:0]) : 32'h0, {24'h0, oe_seen});
      hold(16'h7fff, 4);
      apb(1'b0, `DTQ_PKMAX_OFF, 32'h00000000);
      chk_word("peak max frozen", {16'h0000, `DTQ_NEG_FS}, rd);
    end
    $display("test software done");
    // and of two commands in both orders, then command and level
    for (k = 0; k < 2; k = k + 1)
    begin
      arm((32'h1 << 4) | (32'h1 << `DTQ_COND_AND) | (32'h1 << `DTQ_COND_PAIR), 16'h0, 16'h0);
      apb(1'b1, `DTQ_CTRL_OFF, 32'h1 << (k ? `DTQ_CTRL_BUSTRG : `DTQ_CTRL_SWTRG));
      wait_fire(1'b0, 8);
      apb(1'b1, `DTQ_CTRL_OFF, 32'h1 << (k ? `DTQ_CTRL_SWTRG : `DTQ_CTRL_BUSTRG));
      wait_fire(1'b1, 8);
    end
    hold(16'h2000, 0);
    arm((32'h5 << 4) | (32'h1 << `DTQ_COND_AND) | (32'h1 << `DTQ_COND_PAIR), 16'h1000, 16'h0);
    wait_fire(1'b0, 8);
    apb(1'b1, `DTQ_CTRL_OFF, 32'h1 << `DTQ_CTRL_SWTRG);
    wait_fire(1'b1, 8);
    $display("test and done");
    // level rounding, then running peaks and gate
    hold(16'h0000, 0);
    arm({28'h0000000, `DTQ_ABOVE_LEVEL_CODE}, 16'h10c0, 16'h0000);
    hold(16'h11ff, 0);
    wait_fire(1'b0, 8);
    hold(16'h1200, 0);
    wait_fire(1'b1, 6);
    mx = 16'h1200;
    mn = {thr_of(16'h0000), 8'h00};
    for (i = 0; i < 20; i = i + 1)
    begin
      rv = $urandom;
      hold(rv[15:0], 0);
      if ($signed(rv[15:0]) > $signed(mx))
        mx = rv[15:0];
      if ($signed(rv[15:0]) < $signed(mn))
        mn = rv[15:0];
    end
    for (k = 0; k < 2; k = k + 1)
    begin
      hold(16'h0000, 4);
      apb(1'b0, `DTQ_PKMAX_OFF, 32'h00000000);
      chk_word("peak max", {16'h0000, mx}, rd);
      apb(1'b0, `DTQ_PKMIN_OFF, 32'h00000000);
      chk_word("peak min", {16'h0000, mn}, rd);
      ext_gate <= 1'b1;
      hold(16'h0000, 4);
      hold(16'h7fff, 3);
      hold(16'h8001, 3);
      hold(16'h0000, 3);
      ext_gate <= 1'b0;
    end
    $display("test peaks done");
    // window of two levels, leaving on either side
    for (k = 0; k < 2; k = k + 1)
    begin
      hold(16'h0000, 0);
      arm(32'h5 | (32'h6 << 4) | (32'h1 << `DTQ_COND_PAIR), 16'h1000, 16'hf000);
      wait_fire(1'b0, 6);
      hold(k ? 16'h2000 : 16'he000, 0);
      wait_fire(1'b1, 6);
    end
    // slope in all four quadrants
    for (k = 0; k < 4; k = k + 1)
    begin
      v = k[1] ? 16'hf000 : 16'h1000;
      hold(k[0] ? v + 16'h0200 : v - 16'h0200, 0);
      arm(k[0] ? `DTQ_FALLING_SLOPE_CODE : `DTQ_RISING_SLOPE_CODE, v, 16'h0000);
      wait_fire(1'b0, 6);
      hold(k[0] ? v - 16'h0200 : v + 16'h0200, 0);
      wait_fire(1'b1, 6);
    end
    // external edge that starts at its active level
    for (k = 0; k < 2; k = k + 1)
    begin
      ext_trig <= (k == 0);
      hold(16'h0000, 4);
      arm(`DTQ_EXT_RISE_CODE + k[3:0], 16'h0000, 16'h0000);
      wait_fire(1'b0, 8);
      ext_trig <= (k != 0);
      hold(16'h0000, 4);
      ext_trig <= (k == 0);
      wait_fire(1'b1, 8);
    end
    $display("test levels and edges done");
    // backplane in on line 3, out on line 5, both polarities
    for (k = 0; k < 2; k = k + 1)
    begin
      apb(1'b1, `DTQ_EDGES_OFF, k);
      arm(`DTQ_BACKPLANE_CODE | (32'h3 << `DTQ_COND_INSEL_LSB) | (32'h1 << `DTQ_COND_OUTEN) |
        (32'h5 << `DTQ_COND_OUTSEL_LSB), 16'h0000, 16'h0000);
      @(posedge clk);
      bp_req <= 1'b1;
      bp_line <= 3'h3;
      @(posedge clk);
      bp_req <= 1'b0;
      wait_fire(k == 0, 6);
      if (k)
        wait_fire(1'b1, 10);
      chk_word("backplane out", 32'h00000020, {24'h0, oe_seen});
      hold(16'h0000, 8);
    end
    // realtime interval
    rv = $urandom;
    apb(1'b1, `DTQ_RTINT_OFF, 32'h2 + rv[1:0]);
    rt_gap(i);
    rt_gap(i);
    rt_gap(i);
    chk_word("rt interval", 32'h2 + rv[1:0], i);
    // separator swap in the report text
    apb(1'b1, `DTQ_DELIM_OFF, 32'h0000002c);
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge clk);
      rpt_c <= k ? 8'h61 : 8'h3b;
      rpt_v <= 1'b1;
      @(posedge clk);
      rpt_v <= 1'b0;
      @(posedge clk);
      chk_word("report char", k ? 32'h61 : 32'h2c, {24'h0, rpt_co});
      chk_bit("report valid", 1'b1, rpt_vo);
    end
    $display("test side outputs done");
    end_sim;
  end
endmodule
